// File: ssc_pkg.sv
package ssc_pkg;
  // Clock rate
  localparam int CLK_FREQ_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  // Oscillator stabilization, in master clock cycles
  localparam int STABILIZE_CYCLES = 512;
  localparam logic [9:0] STABILIZE_COUNT = 10'h200;
  // Power-up time, in microseconds (typical / maximum)
  localparam int POWER_ON_TYP_US = 40;
  localparam int POWER_ON_MAX_US = 200;
  // Power-on delay before stabilization: typical minus stabilization time
  localparam int POWER_ON_DELAY_CYCLES = POWER_ON_TYP_US * CLK_FREQ_MHZ - STABILIZE_CYCLES;
  // Shutdown delay, in microseconds
  localparam int SHUTDOWN_DELAY_US = 7;
  localparam int SHUTDOWN_DELAY_CYCLES = SHUTDOWN_DELAY_US * CLK_FREQ_MHZ;
  // Nonvolatile write time, in milliseconds (min / max)
  localparam int NVM_WRITE_MIN_MS = 10;
  localparam int NVM_WRITE_MAX_MS = 20;
  localparam int NVM_WRITE_CYCLES = NVM_WRITE_MIN_MS * 1000 * CLK_FREQ_MHZ;
  // Serial port fast-mode clock limit
  localparam int SERIAL_CLOCK_MAX_KHZ = 400;
  // Prescaler exponent saturation
  localparam logic [3:0] PRESCALE_MAX = 4'h8;
  // Dither rate divider exponents (1024, 2048, 4096)
  localparam logic [3:0] DITHER_SHIFT_BASE = 4'hA;
  // Counter widths
  localparam int DELAY_WIDTH = 24;
  localparam int DITHER_WIDTH = 13;
  // Reset values
  localparam logic [DELAY_WIDTH-1:0] DELAY_RESET = 24'h000000;
  localparam logic [8:0] DIVIDE_RESET = 9'h000;

  typedef enum logic [1:0] {
    SSC_POWER_ON = 2'b00,
    SSC_STABILIZE = 2'b01,
    SSC_RUN = 2'b11,
    SSC_SHUTDOWN = 2'b10
  } ssc_state_type;
endpackage

// File: ssc_divider.sv
`timescale 1ns/1ps
module ssc_divider
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [3:0] prescale,
  // Output
  output logic clkOut
);
  typedef struct packed {
    logic [8:0] count;
    logic [3:0] shift;
    logic out;
  } ssc_div_type;

  ssc_div_type state;
  ssc_div_type next_state;
  logic [3:0] satShift;
  logic [8:0] halfLimit;

  always_comb
  begin
    next_state = state;
    satShift = (prescale > PRESCALE_MAX) ? PRESCALE_MAX : prescale;
    halfLimit = 9'((9'h001 << state.shift) >> 1);
    if (!run)
    begin
      next_state.count = DIVIDE_RESET;
      next_state.out = 1'b0;
      next_state.shift = satShift;
    end
    else if (state.shift == 4'h0)
    begin
      next_state.out = ~state.out;
      next_state.shift = satShift;
    end
    else if (state.count + 9'h001 >= halfLimit)
    begin
      // New setting taken only at a half-period edge, so at most one odd period
      next_state.count = DIVIDE_RESET;
      next_state.out = ~state.out;
      next_state.shift = satShift;
    end
    else
    begin
      next_state.count = state.count + 9'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign clkOut = state.out;
endmodule

// File: ssc_output_control.sv
`timescale 1ns/1ps
module ssc_output_control
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control pins
  input wire logic spread_enable_pin,
  input wire logic output_enable_pin,
  input wire logic power_down_pin_n,
  // Settings from the serial register file
  input wire logic [3:0] prescale,
  input wire logic [1:0] ditherRate,
  input wire logic [1:0] ditherAmount,
  input wire logic outputEnableBit_n,
  input wire logic idle_drive_select,
  input wire logic eeprom_write_defer,
  // Serial bus events
  input wire logic busStop,
  input wire logic settingsWritten,
  input wire logic storeCommand,
  // Clock output pin
  output logic clkOut,
  output logic clkOutEn,
  // Status
  output logic oscRunning,
  output logic nvmBusy,
  output logic nvmCommit,
  // Dither offset to oscillator trim, signed
  output logic signed [7:0] ditherOffset
);
  typedef struct packed {
    logic [2:0] spreadSync;
    logic [2:0] enableSync;
    logic [2:0] wakeSync;
    logic spread;
    logic enable;
    logic wake;
    ssc_state_type fsm;
    logic oscRun;
    logic [DELAY_WIDTH-1:0] delay;
    logic [DITHER_WIDTH-1:0] ditherCount;
    logic ditherDown;
    logic signed [7:0] ditherLevel;
    logic pending;
    logic [DELAY_WIDTH-1:0] nvmCount;
    logic nvmBusy;
    logic nvmCommit;
    logic outEn;
    logic outVal;
  } ssc_ctl_type;

  ssc_ctl_type state;
  ssc_ctl_type next_state;
  logic divRun;
  logic divClk;
  logic signed [7:0] ditherPeak;
  logic [DITHER_WIDTH-1:0] ditherStepLimit;
  logic ditherOn;
  logic driveWanted;

  ssc_divider divider (
    .clk(clk),
    .rst_n(rst_n),
    .run(divRun),
    .prescale(prescale),
    .clkOut(divClk)
  );

  assign divRun = (state.fsm == SSC_RUN) || (state.fsm == SSC_SHUTDOWN);

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_state = state;
    ditherPeak = 8'sh00;
    ditherStepLimit = '0;
    // Three-stage synchronizers; change taken when stages two and three agree
    next_state.spreadSync = {state.spreadSync[1:0], spread_enable_pin};
    next_state.enableSync = {state.enableSync[1:0], output_enable_pin};
    next_state.wakeSync = {state.wakeSync[1:0], power_down_pin_n};
    if (state.spreadSync[2] == state.spreadSync[1])
    begin
      next_state.spread = state.spreadSync[2];
    end
    if (state.enableSync[2] == state.enableSync[1])
    begin
      next_state.enable = state.enableSync[2];
    end
    if (state.wakeSync[2] == state.wakeSync[1])
    begin
      next_state.wake = state.wakeSync[2];
    end

    // Power sequencing
    unique case (state.fsm)
      SSC_POWER_ON:
      begin
        next_state.delay = state.delay + 1'b1;
        if (state.delay >= DELAY_WIDTH'(POWER_ON_DELAY_CYCLES - 1))
        begin
          next_state.delay = DELAY_RESET;
          next_state.fsm = SSC_STABILIZE;
        end
      end
      SSC_STABILIZE:
      begin
        if (!state.wake)
        begin
          next_state.delay = DELAY_RESET;
        end
        else if (state.delay >= DELAY_WIDTH'(STABILIZE_COUNT - 10'h001))
        begin
          next_state.delay = DELAY_RESET;
          next_state.fsm = SSC_RUN;
        end
        else
        begin
          next_state.delay = state.delay + 1'b1;
        end
      end
      SSC_RUN:
      begin
        if (!state.wake)
        begin
          next_state.delay = DELAY_RESET;
          next_state.fsm = SSC_SHUTDOWN;
        end
      end
      SSC_SHUTDOWN:
      begin
        if (state.wake)
        begin
          next_state.fsm = SSC_RUN;
        end
        else if (state.delay >= DELAY_WIDTH'(SHUTDOWN_DELAY_CYCLES - 1))
        begin
          next_state.delay = DELAY_RESET;
          next_state.fsm = SSC_STABILIZE;
        end
        else
        begin
          next_state.delay = state.delay + 1'b1;
        end
      end
    endcase
    // Registered copy of the running state for the status pin
    next_state.oscRun = (next_state.fsm == SSC_RUN) || (next_state.fsm == SSC_SHUTDOWN);

    // Symmetric triangle dither, rate set by the dither-rate field
    ditherOn = state.spread && (ditherRate != 2'b00) && divRun;
    ditherPeak = 8'sh08 <<< ditherAmount;
    ditherStepLimit = DITHER_WIDTH'((13'h0001 << (DITHER_SHIFT_BASE + 4'(ditherRate) - 4'h1))
                      / (13'h0001 << 5));
    if (!ditherOn)
    begin
      next_state.ditherLevel = 8'sh00;
      next_state.ditherCount = '0;
      next_state.ditherDown = 1'b0;
    end
    else if (state.ditherCount + 1'b1 >= ditherStepLimit)
    begin
      next_state.ditherCount = '0;
      if (state.ditherDown)
      begin
        next_state.ditherLevel = state.ditherLevel - 8'sh01;
        if (state.ditherLevel - 8'sh01 <= -ditherPeak)
        begin
          next_state.ditherDown = 1'b0;
        end
      end
      else
      begin
        next_state.ditherLevel = state.ditherLevel + 8'sh01;
        if (state.ditherLevel + 8'sh01 >= ditherPeak)
        begin
          next_state.ditherDown = 1'b1;
        end
      end
    end
    else
    begin
      next_state.ditherCount = state.ditherCount + 1'b1;
    end

    // Nonvolatile commit after the bus stop or on a store command; new writes set over the clear
    if (settingsWritten && !eeprom_write_defer)
    begin
      next_state.pending = 1'b1;
    end
    next_state.nvmCommit = 1'b0;
    if (state.nvmBusy)
    begin
      if (state.nvmCount >= DELAY_WIDTH'(NVM_WRITE_CYCLES - 1))
      begin
        next_state.nvmBusy = 1'b0;
        next_state.nvmCount = DELAY_RESET;
      end
      else
      begin
        next_state.nvmCount = state.nvmCount + 1'b1;
      end
    end
    else if ((busStop && state.pending) || storeCommand)
    begin
      next_state.nvmBusy = 1'b1;
      next_state.nvmCommit = 1'b1;
      next_state.pending = settingsWritten && !eeprom_write_defer;
    end

    // Output drive: pin OR inverted bit, gated by power state
    driveWanted = (state.enable || !outputEnableBit_n) && (state.fsm == SSC_RUN);
    if (driveWanted)
    begin
      next_state.outEn = 1'b1;
      next_state.outVal = divClk;
    end
    else
    begin
      next_state.outEn = idle_drive_select;
      next_state.outVal = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign clkOut = state.outVal;
  assign clkOutEn = state.outEn;
  assign oscRunning = state.oscRun;
  assign nvmBusy = state.nvmBusy;
  assign nvmCommit = state.nvmCommit;
  assign ditherOffset = state.ditherLevel;
endmodule

// File: ssc_output_control_properties.sv
`timescale 1ns/1ps
module ssc_output_control_properties
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins and settings
  input wire logic spread_enable_pin,
  input wire logic output_enable_pin,
  input wire logic power_down_pin_n,
  input wire logic [1:0] ditherRate,
  input wire logic outputEnableBit_n,
  input wire logic idle_drive_select,
  input wire logic eeprom_write_defer,
  input wire logic busStop,
  input wire logic storeCommand,
  // Outputs
  input wire logic clkOut,
  input wire logic clkOutEn,
  input wire logic oscRunning,
  input wire logic nvmBusy,
  input wire logic nvmCommit,
  input wire logic signed [7:0] ditherOffset
);
  typedef struct packed {
    logic [9:0] down;
    logic [9:0] off;
  } ssc_chk_type;
  ssc_chk_type cnt;
  ssc_chk_type next_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Saturating run lengths of power-down and of stopped oscillator after wake
  always_comb
  begin
    next_cnt.down = power_down_pin_n ? 10'h000 : cnt.down + {9'h000, ~&cnt.down};
    next_cnt.off = (oscRunning || !power_down_pin_n) ? 10'h000 : cnt.off + {9'h000, ~&cnt.off};
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end
  ////////////////////////////////////////
  commit_pulse_a:
    assert property (nvmCommit |=> !nvmCommit && nvmBusy) else $error("bad commit pulse");
  busy_refuse_a:
    assert property (nvmBusy && busStop |=> !nvmCommit) else $error("commit while busy");
  defer_hold_a:
    assert property ((eeprom_write_defer && !storeCommand)[*2] |=> !nvmCommit)
      else $error("commit while deferred");
  down_quiet_a:
    assert property ((!power_down_pin_n)[*7] |-> !clkOut) else $error("clock in power-down");
  idle_low_a:
    assert property ((!power_down_pin_n && idle_drive_select)[*7] |-> clkOutEn)
      else $error("idle not driven");
  idle_float_a:
    assert property ((!power_down_pin_n && !idle_drive_select)[*7] |-> !clkOutEn)
      else $error("idle not floating");
  gate_off_a:
    assert property ((!output_enable_pin && outputEnableBit_n)[*8] |-> !clkOut)
      else $error("clock while gated");
  spread_off_a:
    assert property ((!spread_enable_pin || ditherRate == 2'h0)[*6] |-> ditherOffset == 8'sh00)
      else $error("dither while off");
  dither_span_a:
    assert property (ditherOffset <= 8'sh40 && ditherOffset >= -8'sh40) else $error("dither span");
  osc_stop_a:
    assert property (cnt.down >= 10'h2D0 |-> !oscRunning) else $error("oscillator not stopped");
  stab_wait_a:
    assert property ($rose(oscRunning) |-> cnt.off >= 10'h200 && !clkOut) else $error("short wait");
endmodule
bind ssc_output_control ssc_output_control_properties i_ssc_output_control_properties (
  .clk(clk), .rst_n(rst_n), .spread_enable_pin(spread_enable_pin),
  .output_enable_pin(output_enable_pin), .power_down_pin_n(power_down_pin_n),
  .ditherRate(ditherRate), .outputEnableBit_n(outputEnableBit_n),
  .idle_drive_select(idle_drive_select), .eeprom_write_defer(eeprom_write_defer),
  .busStop(busStop), .storeCommand(storeCommand), .clkOut(clkOut), .clkOutEn(clkOutEn),
  .oscRunning(oscRunning), .nvmBusy(nvmBusy), .nvmCommit(nvmCommit), .ditherOffset(ditherOffset));

// File: ssc_clock_sink.sv
`timescale 1ns/1ps
module ssc_clock_sink
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Clock pin
  input wire logic clkOut,
  input wire logic clkOutEn,
  // Rising edges seen while driven
  output logic [15:0] edgeCount
);
  typedef struct packed {
    logic level;
    logic [15:0] edges;
  } ssc_sink_type;
  ssc_sink_type st;
  ssc_sink_type next_st;
  logic pin;
  // Floating pin has no pull: show a changing level
  assign pin = clkOutEn ? clkOut : ~st.level;
  assign edgeCount = st.edges;
  always_comb
  begin
    next_st.level = pin;
    next_st.edges = st.edges + {15'h0000, clkOutEn & pin & ~st.level};
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end
endmodule

// File: tb_spread_clock_output_control.sv
`timescale 1ns/1ps
module tb_spread_clock_output_control import ssc_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, spread = 1'b0, oe = 1'b0, pdnN = 1'b1, oeBitN = 1'b1;
  logic idle = 1'b0, defer = 1'b0, busStop = 1'b0, written = 1'b0, store = 1'b0;
  logic [3:0] prescale = 4'h1;
  logic [1:0] rate = 2'h0, amount = 2'h0;
  logic clkOut, clkOutEn, oscRunning, nvmBusy, nvmCommit;
  logic signed [7:0] ditherOffset, hi, lo;
  logic [15:0] edgeCount, n16;
  logic [31:0] lfsrState = 32'hCB7207D3;
  int failures = 0, cmp_count = 0, n;
  ssc_output_control i_ssc_output_control (.clk(clk), .rst_n(rst_n),
    .spread_enable_pin(spread), .output_enable_pin(oe), .power_down_pin_n(pdnN),
    .prescale(prescale), .ditherRate(rate), .ditherAmount(amount), .outputEnableBit_n(oeBitN),
    .idle_drive_select(idle), .eeprom_write_defer(defer), .busStop(busStop),
    .settingsWritten(written), .storeCommand(store), .clkOut(clkOut), .clkOutEn(clkOutEn),
    .oscRunning(oscRunning), .nvmBusy(nvmBusy), .nvmCommit(nvmCommit),
    .ditherOffset(ditherOffset));
  ssc_clock_sink i_ssc_clock_sink (.clk(clk), .rst_n(rst_n), .clkOut(clkOut),
    .clkOutEn(clkOutEn), .edgeCount(edgeCount));
  initial
  begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] expEdges(input logic [3:0] p);
    return 16'h0400 >> ((p > PRESCALE_MAX) ? PRESCALE_MAX : p);
  endfunction
  task automatic results();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (e !== s)
    begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, e, s);
    end
  endtask
  task automatic waitOsc();
    n = 0;
    while (oscRunning !== 1'b1 && n < 30000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 30000)
    begin
      check("osc start", 1, oscRunning);
      results();
    end
  endtask
  task automatic edges(input logic [3:0] p);
    @(posedge clk);
    prescale <= p;
    repeat (300) @(posedge clk);
    n16 = edgeCount;
    repeat (1024) @(posedge clk);
    n16 = edgeCount - n16;
  endtask
  task automatic pulse(input logic [2:0] which);
    @(posedge clk);
    written <= which[0];
    busStop <= which[1];
    store <= which[2];
    @(posedge clk);
    written <= 1'b0;
    busStop <= 1'b0;
    store <= 1'b0;
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    waitOsc();
    check("power up", 1, n >= 512 && n <= 20000);
    oe <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      lfsrState = lfsr(lfsrState);
      edges(i == 0 ? 4'hF : lfsrState[3:0] | 4'h1);
      check("edges", 1, n16 + 1 >= expEdges(prescale) && n16 <= expEdges(prescale) + 1);
    end
    oe <= 1'b0;
    edges(4'h1);
    check("gated edges", 1, n16 === 16'h0000 && oscRunning === 1'b1);
    oeBitN <= 1'b0;
    edges(4'h1);
    check("bit edges", 1, n16 + 1 >= 16'h0200 && n16 <= 16'h0201);
    spread <= 1'b1;
    repeat (20) @(posedge clk);
    check("no rate", 0, ditherOffset);
    for (int i = 1; i < 4; i++)
    begin
      lfsrState = lfsr(lfsrState);
      spread <= 1'b0;
      repeat (10) @(posedge clk);
      check("spread low", 0, ditherOffset);
      rate <= i[1:0];
      amount <= lfsrState[1:0];
      spread <= 1'b1;
      hi = 8'sh00;
      lo = 8'sh00;
      repeat (3 * (8 << lfsrState[1:0]) * (16 << i) + 40)
      begin
        @(posedge clk);
        hi = (ditherOffset > hi) ? ditherOffset : hi;
        lo = (ditherOffset < lo) ? ditherOffset : lo;
      end
      check("peak", 8'sh08 <<< amount, hi);
      check("trough", -(8'sh08 <<< amount), lo);
    end
    defer <= 1'b1;
    pulse(3'h1);
    pulse(3'h2);
    check("deferred", 0, nvmCommit);
    pulse(3'h4);
    check("store", 1, nvmCommit);
    // Mid-run reset clears the long commit so the automatic path can run
    rst_n <= 1'b0;
    defer <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    waitOsc();
    check("power up", 1, n >= 512 && n <= 20000);
    pulse(3'h1);
    pulse(3'h2);
    check("commit", 1, nvmCommit);
    @(posedge clk);
    check("busy", 2'h1, {nvmCommit, nvmBusy});
    pulse(3'h3);
    check("refused", 0, nvmCommit);
    for (int i = 0; i < 2; i++)
    begin
      idle <= i[0];
      pdnN <= 1'b0;
      repeat (10) @(posedge clk);
      check("idle", {i[0], 1'b0}, {clkOutEn, clkOut});
      repeat (800) @(posedge clk);
      check("osc stop", 0, oscRunning);
      pdnN <= 1'b1;
      waitOsc();
      check("wake", 1, n >= 512 && n <= 1000);
    end
    results();
  end
endmodule
